// file: core/madc_pkg.sv
// package for the monitor converter result registers
package madc_pkg;
   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_BAT_HI  = 8'h1d;
   localparam logic [7:0] OFF_BAT_LO  = 8'h1e;
   localparam logic [7:0] OFF_SYS_HI  = 8'h1f;
   localparam logic [7:0] OFF_SYS_LO  = 8'h20;
   localparam logic [7:0] OFF_TS_HI   = 8'h21;
   localparam logic [7:0] OFF_TS_LO   = 8'h22;
   localparam logic [7:0] OFF_DIE_HI  = 8'h23;
   localparam logic [7:0] OFF_DIE_LO  = 8'h24;
   localparam logic [7:0] OFF_RST_CTL = 8'h25;
   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int         BIT_REG_RST   = 7;
   localparam int         BIT_DIE_RSVD  = 7;
   localparam logic [7:0] RESULT_RST    = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   typedef enum logic [1:0] {
      MADC_IDLE  = 2'b00,
      MADC_CLEAR = 2'b01
   } madc_rst_e;

   // one coherent conversion set, 16 bits per channel
   typedef struct packed {
      logic [15:0] bat;
      logic [15:0] sys;
      logic [15:0] ts;
      logic [15:0] die;
   } madc_result_s;

   typedef struct packed {
      madc_result_s res;
      madc_rst_e    rst_st;
      logic         rd_vld;
      logic [7:0]   rd_data;
   } madc_state_s;
endpackage

// file: core/madc_result_regs.sv
// read-only result registers of the monitoring converter
//
// Our own choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none

module madc_result_regs (
   input  wire logic                 i_sys_clk,
   input  wire logic                 i_reset_n,
   input  wire logic [7:0]           i_addr,
   input  wire logic [7:0]           i_wdata,
   input  wire logic                 i_wr,
   input  wire logic                 i_rd,
   output logic      [7:0]           o_rdata,
   input  wire logic                 i_conv_valid,
   input  wire madc_pkg::madc_result_s i_conv,
   input  wire logic                 i_watchdog_expired,
   output logic                      o_reg_reset,
   output logic                      o_safety_timer_reset
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   madc_pkg::madc_state_s st_ff;
   madc_pkg::madc_state_s nxt_st;
   logic                  rst_req;

   function automatic logic [7:0] read_mux(input madc_pkg::madc_state_s s, input logic [7:0] a);
      logic [7:0] r;
      r = madc_pkg::UNMAPPED_READ;
      case (a)
         madc_pkg::OFF_BAT_HI:  r = s.res.bat[15:8];
         madc_pkg::OFF_BAT_LO:  r = s.res.bat[7:0];
         madc_pkg::OFF_SYS_HI:  r = s.res.sys[15:8];
         madc_pkg::OFF_SYS_LO:  r = s.res.sys[7:0];
         madc_pkg::OFF_TS_HI:   r = s.res.ts[15:8];
         madc_pkg::OFF_TS_LO:   r = s.res.ts[7:0];
         madc_pkg::OFF_DIE_HI:  r = {1'b0, s.res.die[14:8]};
         madc_pkg::OFF_DIE_LO:  r = s.res.die[7:0];
         madc_pkg::OFF_RST_CTL: r = {(s.rst_st == madc_pkg::MADC_CLEAR), 7'h00};
         default:               r = madc_pkg::UNMAPPED_READ;
      endcase
      return r;
   endfunction

   assign rst_req = i_wr && (i_addr == madc_pkg::OFF_RST_CTL) && i_wdata[madc_pkg::BIT_REG_RST];

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      nxt_st         = st_ff;
      nxt_st.rd_vld  = i_rd;
      nxt_st.rd_data = i_rd ? read_mux(st_ff, i_addr) : madc_pkg::UNMAPPED_READ;
      // writes to result offsets are dropped: the bytes are read-only
      case (st_ff.rst_st)
         madc_pkg::MADC_IDLE: begin
            if (rst_req) begin
               nxt_st.rst_st = madc_pkg::MADC_CLEAR;
            end else if (i_conv_valid) begin
               // whole set captured in one edge so hi/lo pairs never tear
               nxt_st.res = i_conv;
            end
         end
         madc_pkg::MADC_CLEAR: begin
            // defaults restored, bit clears itself after this cycle
            nxt_st.res    = '0;
            nxt_st.rst_st = madc_pkg::MADC_IDLE;
         end
         default: nxt_st.rst_st = madc_pkg::MADC_IDLE;
      endcase
      // watchdog expiry intentionally has no effect on results
      if (i_watchdog_expired) begin
         nxt_st.res = nxt_st.res;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         st_ff.res     <= '0;
         st_ff.rst_st  <= madc_pkg::MADC_IDLE;
         st_ff.rd_vld  <= 1'b0;
         st_ff.rd_data <= madc_pkg::RESULT_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_rdata              = st_ff.rd_data;
   assign o_reg_reset          = (st_ff.rst_st == madc_pkg::MADC_CLEAR);
   assign o_safety_timer_reset = (st_ff.rst_st == madc_pkg::MADC_CLEAR);

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);

   chk_die_rsvd_zero: assert property (i_rd && i_addr == madc_pkg::OFF_DIE_HI |=> o_rdata[7] == 1'b0)
      else $error("die high reserved bit not zero");
   chk_rst_clears: assert property (o_reg_reset |=> st_ff.res == '0)
      else $error("register reset did not clear results");
   chk_rst_selfclr: assert property (rst_req && !o_reg_reset |=> o_reg_reset ##1 !o_reg_reset)
      else $error("register reset bit did not self clear");
   chk_capture: assert property (i_conv_valid && !rst_req && !o_reg_reset |=> st_ff.res == $past(i_conv))
      else $error("conversion not captured coherently");
   chk_hold: assert property (!i_conv_valid && !rst_req && !o_reg_reset |=> $stable(st_ff.res))
      else $error("result changed without conversion");
   chk_bat_lo: assert property (i_rd && i_addr == madc_pkg::OFF_BAT_LO |=> o_rdata == $past(st_ff.res.bat[7:0]))
      else $error("battery low byte wrong");
   chk_sys_hi: assert property (i_rd && i_addr == madc_pkg::OFF_SYS_HI |=> o_rdata == $past(st_ff.res.sys[15:8]))
      else $error("system high byte wrong");
   chk_ts_lo: assert property (i_rd && i_addr == madc_pkg::OFF_TS_LO |=> o_rdata == $past(st_ff.res.ts[7:0]))
      else $error("thermistor low byte wrong");

   cov_reg_reset: cover property (rst_req ##1 o_reg_reset ##1 !o_reg_reset);
   cov_capture:   cover property (i_conv_valid ##1 i_rd && i_addr == madc_pkg::OFF_DIE_HI);
   cov_back2back: cover property (i_rd ##1 i_rd);
endmodule
`default_nettype wire

// file: tb/test_madc_result_regs.sv
// self-checking bench for the monitor converter result registers
`timescale 1ns/10ps
`default_nettype none
module test_madc_result_regs;
   logic                   i_sys_clk = 1'b0;
   logic                   i_reset_n = 1'b0;
   logic [7:0]             i_addr = 8'h00;
   logic [7:0]             i_wdata = 8'h00;
   logic                   i_wr = 1'b0;
   logic                   i_rd = 1'b0;
   logic                   i_conv_valid = 1'b0;
   logic                   i_watchdog_expired = 1'b0;
   madc_pkg::madc_result_s i_conv = '0;
   madc_pkg::madc_result_s pat;
   logic [7:0]             o_rdata;
   logic                   o_reg_reset;
   logic                   o_safety_timer_reset;
   int                     n_mismatch = 0;
   int                     checks_done = 0;
   always #2 i_sys_clk = ~i_sys_clk;
   madc_result_regs dut_u (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_conv_valid(i_conv_valid), .i_conv(i_conv),
      .i_watchdog_expired(i_watchdog_expired), .o_reg_reset(o_reg_reset),
      .o_safety_timer_reset(o_safety_timer_reset));
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe, so sample there
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_sys_clk);
      i_rd <= 1'b1; i_addr <= a;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      #1 chk("read data", exp, o_rdata);
   endtask
   // offsets 1dh..24h hold hi/lo pairs of bat, sys, ts, die in turn
   task automatic rd_all(input madc_pkg::madc_result_s r);
      logic [7:0] e;
      for (int k = 0; k < 8; k++) begin
         e = r[63-8*k -: 8];
         if (k == 6) e[madc_pkg::BIT_DIE_RSVD] = 1'b0;
         rd(madc_pkg::OFF_BAT_HI + 8'(k), e);
      end
   endtask
   task automatic conv(input madc_pkg::madc_result_s r);
      @(posedge i_sys_clk);
      i_conv <= r; i_conv_valid <= 1'b1;
      @(posedge i_sys_clk);
      i_conv_valid <= 1'b0; i_conv <= ~r;
   endtask
   task automatic test_done();
      if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #20000;
      n_mismatch++;
      test_done();
   end
   initial begin
      repeat (12) @(posedge i_sys_clk);
      i_reset_n <= 1'b1;
      rd_all('0);
      pat = {16'h8a51, 16'h7fc3, 16'h83a6, 16'hd5e9};
      conv(pat);
      rd_all(pat);
      wr(madc_pkg::OFF_SYS_HI, 8'h11);
      wr(madc_pkg::OFF_DIE_HI, 8'hff);
      i_watchdog_expired <= 1'b1;
      repeat (4) @(posedge i_sys_clk);
      i_watchdog_expired <= 1'b0;
      rd_all(pat);
      rd(8'h40, madc_pkg::UNMAPPED_READ);
      wr(madc_pkg::OFF_RST_CTL, 8'h80);
      #1 chk("reg reset", 8'h01, {7'h00, o_reg_reset});
      chk("timer reset", 8'h01, {7'h00, o_safety_timer_reset});
      @(posedge i_sys_clk);
      #1 chk("reset bit clears", 8'h00, {7'h00, o_reg_reset});
      rd_all('0);
      conv(~pat);
      rd_all(~pat);
      @(posedge i_sys_clk);
      i_reset_n <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
      i_reset_n <= 1'b1;
      rd_all('0);
      test_done();
   end
endmodule
`default_nettype wire
